//--- rtl/twp_pkg.sv
// package: register map, field positions and reset values of the timer/port control block
package twp_pkg;
    localparam logic [3:0] A_TIMER_CTRL   = 4'h1;
    localparam logic [3:0] A_PORT5_DIR    = 4'h5;
    localparam logic [3:0] A_PORT6_DIR    = 4'h6;
    localparam logic [3:0] A_PRESCALE_CNT = 4'ha;
    localparam logic [3:0] A_PULLDOWN     = 4'hb;
    localparam logic [3:0] A_OPENDRAIN    = 4'hc;
    localparam logic [3:0] A_PULLUP       = 4'hd;
    localparam logic [3:0] A_WDT_PIN      = 4'he;
    localparam logic [3:0] A_IRQ_MASK     = 4'hf;
    // chosen: tick counter value, port data, irq flags (read = flags & mask)
    localparam logic [3:0] A_TICK_COUNT   = 4'h0;
    localparam logic [3:0] A_PORT5_DATA   = 4'h7;
    localparam logic [3:0] A_PORT6_DATA   = 4'h8;
    localparam logic [3:0] A_IRQ_FLAGS    = 4'h9;

    localparam int B_PAB  = 3;
    localparam int B_TE   = 4;
    localparam int B_TS   = 5;
    localparam int B_GIE  = 6;
    localparam int B_ROC  = 4;
    localparam int B_EIS  = 6;
    localparam int B_WATCHDOG_ENABLE = 7;
    localparam int B_TOV  = 0;
    localparam int B_PCH  = 1;
    localparam int B_EXT  = 2;

    localparam logic [7:0] RST_CTRL   = 8'hbf;
    localparam logic [7:0] RST_ONES   = 8'hff;
    localparam logic [7:0] RST_ZERO   = 8'h00;
    localparam logic [7:0] RST_WDTPIN = 8'h80;
    localparam logic [7:0] P5_MASK    = 8'h0f;
    localparam logic [7:0] PD_MASK    = 8'hf7;
    localparam logic [7:0] WP_MASK    = 8'hd0;
    localparam logic [7:0] IRQ_MASK_W = 8'h07;

    // watchdog base period in microseconds, turned into oscillator ticks below
    localparam int WDT_PERIOD_US = 18000;
    localparam int WDT_OSC_KHZ   = 1;   // watchdog rc oscillator sample rate
    localparam int WDT_BASE = WDT_PERIOD_US * WDT_OSC_KHZ / 1000;
endpackage

//--- rtl/twp_ctrl.sv
// timer, watchdog, prescaler and port control register bank
`timescale 1ns/1ps
`default_nettype none
// Function
// - select code sets doubling prescale ratio
// - assign bit gives prescaler to counter/watchdog
// - edge bit: 0 rising, 1 falling
// - source bit: instruction clock or pin
// - global enable cleared/set by instructions
// - direction 1 high-z, 0 output
// - prescaler count readable, counts down
// - pull-down enables active low, bit3 unused
// - open-drain bit per port6 pin
// - pull-up enables active low per pin
// - watchdog enable bit
// - pin function: io or external interrupt
// - interrupt path blocked unless pin function set
// - resistor option reads p50/p51 strap
// - mask bits enable each interrupt source
// - one shared 8-bit prescaler counter
// - counter write clears prescaler when assigned
// - watchdog clear/sleep clear watchdog, prescaler when assigned to it
// - counter counts per instruction cycle or pin edge, per prescaler pulse when assigned
// - watchdog on own oscillator resets on timeout
// - port6 change interrupts or wakes
// - port6 change flag set, software clears
// - overflow flag set, software clears
// - control resets to ones except gie
module twp_ctrl
(
    input  wire logic       core_clk,
    input  wire logic       rst_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       irq_enable_instr,
    input  wire logic       irq_disable_instr,
    input  wire logic       irq_return_instr,
    input  wire logic       irq_taken,
    input  wire logic       watchdog_clear_instr,
    input  wire logic       sleep_instr,
    input  wire logic       sleeping,
    input  wire logic       wdt_osc_tick,
    input  wire logic       tick_pin,
    input  wire logic [3:0] port5_in,
    input  wire logic [7:0] port6_in,
    input  wire logic [1:0] ropt_pin,
    output logic      [3:0] port5_out,
    output logic      [3:0] port5_oe,
    output logic      [7:0] port6_out,
    output logic      [7:0] port6_oe,
    output logic      [7:0] pulldown_en,
    output logic      [7:0] pullup_en,
    output logic            irq_req,
    output logic            wake_req,
    output logic            wdt_reset
);
    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // no reset on the sync flops: they flush within three cycles
    logic [14:0] sync1_q;
    logic [14:0] sync2_q;
    logic [2:0]  wsync_q;
    always_ff @(posedge core_clk)
    begin
        sync1_q <= {ropt_pin, tick_pin, port5_in, port6_in};
        sync2_q <= sync1_q;
        wsync_q <= {wsync_q[1:0], wdt_osc_tick};
    end
    logic [7:0] p6_s;
    logic [3:0] p5_s;
    logic       tpin_s;
    logic [1:0] ropt_s;
    assign p6_s   = sync2_q[7:0];
    assign p5_s   = sync2_q[11:8];
    assign tpin_s = sync2_q[12];
    assign ropt_s = sync2_q[14:13];
    // rising edge of the synchronised watchdog oscillator
    logic wdt_edge;
    assign wdt_edge = wsync_q[1] & ~wsync_q[2];

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] ctrl_q;
    logic [7:0] p5dir_q;
    logic [7:0] p6dir_q;
    logic [7:0] pd_q;
    logic [7:0] od_q;
    logic [7:0] pu_q;
    logic [7:0] wp_q;
    logic [7:0] mask_q;
    logic [3:0] p5dat_q;
    logic [7:0] p6dat_q;
    function automatic logic wr_at(input logic [3:0] a);
        wr_at = reg_wr && reg_addr == a;
    endfunction
    function automatic logic rd_at(input logic [3:0] a);
        rd_at = reg_rd && reg_addr == a;
    endfunction

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            ctrl_q  <= twp_pkg::RST_CTRL;
            p5dir_q <= twp_pkg::P5_MASK;
            p6dir_q <= twp_pkg::RST_ONES;
            pd_q    <= twp_pkg::PD_MASK;
            od_q    <= twp_pkg::RST_ZERO;
            pu_q    <= twp_pkg::RST_ONES;
            wp_q    <= twp_pkg::RST_WDTPIN;
            mask_q  <= twp_pkg::RST_ZERO;
            p5dat_q <= 4'h0;
            p6dat_q <= twp_pkg::RST_ZERO;
        end
        else
        begin
            if (wr_at(twp_pkg::A_TIMER_CTRL))
                ctrl_q <= reg_wdata;
            else if (irq_disable_instr || irq_taken)
                ctrl_q[twp_pkg::B_GIE] <= 1'b0;
            else if (irq_enable_instr || irq_return_instr)
                ctrl_q[twp_pkg::B_GIE] <= 1'b1;
            if (wr_at(twp_pkg::A_PORT5_DIR))
                p5dir_q <= reg_wdata & twp_pkg::P5_MASK;
            if (wr_at(twp_pkg::A_PORT6_DIR))
                p6dir_q <= reg_wdata;
            if (wr_at(twp_pkg::A_PULLDOWN))
                pd_q <= reg_wdata & twp_pkg::PD_MASK;
            if (wr_at(twp_pkg::A_OPENDRAIN))
                od_q <= reg_wdata;
            if (wr_at(twp_pkg::A_PULLUP))
                pu_q <= reg_wdata;
            if (wr_at(twp_pkg::A_WDT_PIN))
                wp_q <= reg_wdata & twp_pkg::WP_MASK;
            if (wr_at(twp_pkg::A_IRQ_MASK))
                mask_q <= reg_wdata & twp_pkg::IRQ_MASK_W;
            if (wr_at(twp_pkg::A_PORT5_DATA))
                p5dat_q <= reg_wdata[3:0];
            if (wr_at(twp_pkg::A_PORT6_DATA))
                p6dat_q <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // pins
    // ------------------------------------------------------------
    logic ext_irq_pin_select;
    assign ext_irq_pin_select = wp_q[twp_pkg::B_EIS];
    assign port5_out   = p5dat_q;
    assign port5_oe    = ~p5dir_q[3:0];
    // open drain only sinks: enable falls away while the data bit is 1
    assign port6_out   = p6dat_q & ~od_q;
    assign port6_oe    = ~p6dir_q & ~(od_q & p6dat_q);
    assign pulldown_en = ~pd_q & twp_pkg::PD_MASK;
    assign pullup_en   = ~pu_q;

    // ------------------------------------------------------------
    // shared prescaler, tick counter and watchdog
    // ------------------------------------------------------------
    logic [7:0] psc_q;
    logic [7:0] tick_q;
    logic [7:0] wdt_q;
    logic       tpin_d1_q;
    logic       prescale_assign;
    logic       ts;
    assign prescale_assign = ctrl_q[twp_pkg::B_PAB];
    assign ts  = ctrl_q[twp_pkg::B_TS];
    logic [2:0] psel;
    assign psel = ctrl_q[2:0];

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            tpin_d1_q <= 1'b0;
        else
            tpin_d1_q <= tpin_s;
    end
    logic       pin_edge;
    logic       tick_src;
    logic       wdt_src;
    assign pin_edge = ctrl_q[twp_pkg::B_TE] ? (tpin_d1_q & ~tpin_s)
                                            : (~tpin_d1_q & tpin_s);
    assign tick_src = ts ? pin_edge : 1'b1;
    assign wdt_src  = wdt_edge;

    // down counter: a prescaled pulse when the selected low bits all zero
    logic       psc_in;
    logic       psc_out;
    logic [7:0] lowmask;
    assign psc_in  = prescale_assign ? wdt_src : tick_src;
    // tick ratio 2^(sel+1), watchdog ratio 2^sel
    assign lowmask = prescale_assign ? ((8'h01 << psel) - 8'h01)
                         : ((8'h02 << psel) - 8'h01);
    assign psc_out = psc_in && ((psc_q & lowmask) == 8'h00);
    logic       psc_clr;
    logic       tick_inc;
    logic       wdt_inc;
    logic       wdt_clr;
    assign wdt_clr  = watchdog_clear_instr || sleep_instr;
    assign psc_clr  = (!prescale_assign && wr_at(twp_pkg::A_TICK_COUNT))
                   || (prescale_assign && wdt_clr);
    assign tick_inc = prescale_assign ? tick_src : psc_out;
    assign wdt_inc  = prescale_assign ? psc_out : wdt_src;

    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            psc_q <= twp_pkg::RST_ZERO;
        else if (psc_clr)
            psc_q <= twp_pkg::RST_ZERO;
        else if (psc_in)
            psc_q <= psc_q - 8'h01;
    end

    logic tick_ovf;
    assign tick_ovf = tick_inc && tick_q == twp_pkg::RST_ONES;
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            tick_q <= twp_pkg::RST_ZERO;
        else if (wr_at(twp_pkg::A_TICK_COUNT))
            tick_q <= reg_wdata;
        else if (tick_inc)
            tick_q <= tick_q + 8'h01;
    end

    logic       wdt_en;
    logic       wdt_to;
    assign wdt_en = wp_q[twp_pkg::B_WATCHDOG_ENABLE];
    assign wdt_to = wdt_en && wdt_inc
                 && wdt_q == 8'(twp_pkg::WDT_BASE - 1);
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            wdt_q     <= twp_pkg::RST_ZERO;
            wdt_reset <= 1'b0;
        end
        else
        begin
            // counts in sleep too; only a clear, a disable or a timeout restarts it
            if (wdt_clr || !wdt_en || wdt_to)
                wdt_q <= twp_pkg::RST_ZERO;
            else if (wdt_inc)
                wdt_q <= wdt_q + 8'h01;
            wdt_reset <= wdt_to;
        end
    end

    // ------------------------------------------------------------
    // interrupt flags
    // ------------------------------------------------------------
    logic [7:0] p6_last_q;
    logic       ext_last_q;
    logic [2:0] flag_q;
    logic       p6_chg;
    logic       ext_fall;
    assign p6_chg   = (p6_s & p6dir_q) != (p6_last_q & p6dir_q);
    assign ext_fall = ext_irq_pin_select && ext_last_q && !p6_s[0];
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
        begin
            p6_last_q  <= twp_pkg::RST_ZERO;
            ext_last_q <= 1'b1;
            flag_q     <= 3'h0;
        end
        else
        begin
            // port6 read re-arms the change compare
            if (rd_at(twp_pkg::A_PORT6_DATA))
                p6_last_q <= p6_s;
            ext_last_q <= p6_s[0];
            // set wins over a same-cycle clear
            if (wr_at(twp_pkg::A_IRQ_FLAGS))
                flag_q <= flag_q & reg_wdata[2:0];
            if (tick_ovf)
                flag_q[twp_pkg::B_TOV] <= 1'b1;
            if (p6_chg && !rd_at(twp_pkg::A_PORT6_DATA))
                flag_q[twp_pkg::B_PCH] <= 1'b1;
            if (ext_fall)
                flag_q[twp_pkg::B_EXT] <= 1'b1;
        end
    end
    logic [2:0] act;
    assign act      = flag_q & mask_q[2:0];
    assign irq_req  = ctrl_q[twp_pkg::B_GIE] && act != 3'h0;
    assign wake_req = sleeping && act[twp_pkg::B_PCH];

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    logic [7:0] rd_d;
    logic [3:0] p5_view;
    logic       resistor_option_enable;
    assign resistor_option_enable = wp_q[twp_pkg::B_ROC];
    // unmapped addresses read as zero, so software sees no stale data
    always_comb
    begin
        p5_view = p5_s;
        if (resistor_option_enable)
            p5_view[1:0] = ropt_s;
        case (reg_addr)
            twp_pkg::A_TICK_COUNT:   rd_d = tick_q;
            twp_pkg::A_TIMER_CTRL:   rd_d = ctrl_q;
            twp_pkg::A_PORT5_DIR:    rd_d = p5dir_q;
            twp_pkg::A_PORT6_DIR:    rd_d = p6dir_q;
            twp_pkg::A_PORT5_DATA:   rd_d = {4'h0, p5_view};
            twp_pkg::A_PORT6_DATA:   rd_d = p6_s;
            twp_pkg::A_IRQ_FLAGS:    rd_d = {5'h00, act};
            twp_pkg::A_PRESCALE_CNT: rd_d = psc_q;
            twp_pkg::A_PULLDOWN:     rd_d = pd_q;
            twp_pkg::A_OPENDRAIN:    rd_d = od_q;
            twp_pkg::A_PULLUP:       rd_d = pu_q;
            twp_pkg::A_WDT_PIN:      rd_d = wp_q;
            twp_pkg::A_IRQ_MASK:     rd_d = mask_q;
            default:                 rd_d = twp_pkg::RST_ZERO;
        endcase
    end
    always_ff @(posedge core_clk)
    begin
        if (!rst_n)
            reg_rdata <= twp_pkg::RST_ZERO;
        else if (reg_rd)
            reg_rdata <= rd_d;
        else
            reg_rdata <= twp_pkg::RST_ZERO;
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_gie_clear: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (irq_disable_instr && !reg_wr) |=> !ctrl_q[twp_pkg::B_GIE])
        else $error("gie not cleared");
    a_ctrl_reset: assert property (
        @(posedge core_clk)
        !rst_n |=> ctrl_q == twp_pkg::RST_CTRL)
        else $error("control reset value wrong");
    a_psc_clear: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!prescale_assign && wr_at(twp_pkg::A_TICK_COUNT)) |=> psc_q == 8'h00)
        else $error("prescaler not cleared on counter write");
    a_wdt_clear: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (prescale_assign && wdt_clr) |=> psc_q == 8'h00 && wdt_q == 8'h00)
        else $error("watchdog clear failed");
    a_tick_wrap: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        tick_ovf && !reg_wr |=> tick_q == 8'h00
            && flag_q[twp_pkg::B_TOV])
        else $error("overflow wrap wrong");
    a_psc_down: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (psc_in && !psc_clr) |=> psc_q == $past(psc_q) - 8'h01)
        else $error("prescaler not counting down");
    a_dir_oe: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (p5dir_q[3:0] & port5_oe) == 4'h0
            && (p6dir_q & port6_oe) == 8'h00)
        else $error("input pin driven");
    a_ext_block: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        (!ext_irq_pin_select && !reg_wr) |=> !flag_q[twp_pkg::B_EXT]
            || $past(flag_q[twp_pkg::B_EXT]))
        else $error("ext irq while pin function off");
    a_irq_gate: assert property (
        @(posedge core_clk) disable iff (!rst_n)
        irq_req |-> ctrl_q[twp_pkg::B_GIE]
            && (flag_q & mask_q[2:0]) != 3'h0)
        else $error("irq without enabled flag");
endmodule
`default_nettype wire

//--- verification/twp_pins_model.sv
// partner model: external circuits on the port, counter and option pins
`timescale 1ns/1ps
`default_nettype none
module twp_pins_model
(
    input  wire logic       osc_run,
    input  wire logic       tick_lvl,
    input  wire logic [1:0] ropt_lvl,
    input  wire logic       ext_en,
    input  wire logic [3:0] ext5,
    input  wire logic [7:0] ext6,
    input  wire logic [3:0] port5_out,
    input  wire logic [3:0] port5_oe,
    input  wire logic [7:0] port6_out,
    input  wire logic [7:0] port6_oe,
    input  wire logic [7:0] pulldown_en,
    input  wire logic [7:0] pullup_en,
    output logic            wdt_osc_tick,
    output logic            tick_pin,
    output logic      [1:0] ropt_pin,
    output logic      [3:0] port5_in,
    output logic      [7:0] port6_in
);
    // rc oscillator stands still until asked, so no stray time-out
    initial
    begin
        wdt_osc_tick = 1'b0;
        forever
        begin
            #160;
            if (osc_run)
                wdt_osc_tick = ~wdt_osc_tick;
        end
    end
    assign tick_pin = tick_lvl;
    assign ropt_pin = ropt_lvl;
    // with ext_en low, an undriven, unpulled pin shows the inverse of its ext5/ext6 level
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            port5_in[i] = port5_oe[i] ? port5_out[i] : ext_en ? ext5[i] :
                (i < 3 && pulldown_en[i]) ? 1'b0 : ~ext5[i];
        for (int i = 0; i < 8; i++)
            port6_in[i] = port6_oe[i] ? port6_out[i] : ext_en ? ext6[i] :
                pullup_en[i] ? 1'b1 :
                (i < 4 && pulldown_en[i + 4]) ? 1'b0 : ~ext6[i];
    end
endmodule
`default_nettype wire

//--- verification/timer_watchdog_port_control_tb.sv
// self-checking bench for the timer, watchdog and port control bank
`timescale 1ns/1ps
`default_nettype none
module timer_watchdog_port_control_tb;
    typedef struct packed
    {logic [3:0] a; logic [7:0] d; logic [7:0] e;} twp_row_s;
    logic       core_clk, rst_n, reg_wr, reg_rd, sleeping, tick_lvl;
    logic       ext_en, osc_run, wdt_osc_tick, tick_pin;
    logic       irq_req, wake_req, wdt_reset;
    logic [3:0] reg_addr, ext5, port5_in, port5_out, port5_oe;
    logic [7:0] reg_wdata, reg_rdata, ext6, port6_in, port6_out, port6_oe;
    logic [7:0] pulldown_en, pullup_en, v0, v1;
    logic [5:0] instr;
    logic [1:0] ropt_lvl, ropt_pin;
    int         fails, num_checks, wd_cnt;
    twp_row_s   rows [9] = '{
        '{twp_pkg::A_PORT5_DIR, 8'hf5, 8'h05},
        '{twp_pkg::A_PORT6_DIR, 8'h3c, 8'h3c},
        '{twp_pkg::A_PULLDOWN, 8'h5a, 8'h52},
        '{twp_pkg::A_OPENDRAIN, 8'ha5, 8'ha5},
        '{twp_pkg::A_PULLUP, 8'h5a, 8'h5a},
        '{twp_pkg::A_WDT_PIN, 8'h6f, 8'h40},
        '{twp_pkg::A_IRQ_MASK, 8'hfa, 8'h02},
        '{twp_pkg::A_TIMER_CTRL, 8'h2b, 8'h2b},
        '{4'h3, 8'h55, 8'h00}};
    twp_row_s   rst_rows [9] = '{
        '{twp_pkg::A_TIMER_CTRL, 8'h00, 8'hbf},
        '{twp_pkg::A_PORT5_DIR, 8'h00, 8'h0f},
        '{twp_pkg::A_PORT6_DIR, 8'h00, 8'hff},
        '{twp_pkg::A_PULLDOWN, 8'h00, 8'hf7},
        '{twp_pkg::A_OPENDRAIN, 8'h00, 8'h00},
        '{twp_pkg::A_PULLUP, 8'h00, 8'hff},
        '{twp_pkg::A_WDT_PIN, 8'h00, 8'h80},
        '{twp_pkg::A_IRQ_MASK, 8'h00, 8'h00},
        '{twp_pkg::A_IRQ_FLAGS, 8'h00, 8'h00}};

    twp_ctrl twp_ctrl_i (.core_clk(core_clk), .rst_n(rst_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_enable_instr(instr[0]), .irq_disable_instr(instr[1]),
        .irq_return_instr(instr[2]), .irq_taken(instr[3]),
        .watchdog_clear_instr(instr[4]), .sleep_instr(instr[5]),
        .sleeping(sleeping), .wdt_osc_tick(wdt_osc_tick),
        .tick_pin(tick_pin), .port5_in(port5_in), .port6_in(port6_in),
        .ropt_pin(ropt_pin), .port5_out(port5_out), .port5_oe(port5_oe),
        .port6_out(port6_out), .port6_oe(port6_oe),
        .pulldown_en(pulldown_en), .pullup_en(pullup_en),
        .irq_req(irq_req), .wake_req(wake_req), .wdt_reset(wdt_reset));
    twp_pins_model twp_pins_model_i (.osc_run(osc_run),
        .tick_lvl(tick_lvl), .ropt_lvl(ropt_lvl), .ext_en(ext_en),
        .ext5(ext5), .ext6(ext6), .port5_out(port5_out),
        .port5_oe(port5_oe), .port6_out(port6_out), .port6_oe(port6_oe),
        .pulldown_en(pulldown_en), .pullup_en(pullup_en),
        .wdt_osc_tick(wdt_osc_tick), .tick_pin(tick_pin),
        .ropt_pin(ropt_pin), .port5_in(port5_in), .port6_in(port6_in));

    // ------------------------------------------------------------
    // bus and check tasks
    // ------------------------------------------------------------
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge core_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    task automatic pulse(input int k);
        @(posedge core_clk);
        instr[k] <= 1'b1;
        @(posedge core_clk);
        instr[k] <= 1'b0;
    endtask
    task automatic chk_out(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic chk_rd(input logic [3:0] a, input logic [7:0] exp);
        logic [7:0] got;
        rd(a, got);
        chk_out(got, exp);
    endtask
    task automatic chk_reset;
        foreach (rst_rows[i])
            chk_rd(rst_rows[i].a, rst_rows[i].e);
    endtask
    // counter advance between two reads, pin flips in between
    task automatic tick_delta(input logic [7:0] ctl, input int gap,
                              input int flips, input logic [7:0] exp);
        wr(twp_pkg::A_TIMER_CTRL, ctl);
        rd(twp_pkg::A_TICK_COUNT, v0);
        repeat (flips)
        begin
            @(posedge core_clk);
            tick_lvl <= ~tick_lvl;
            cyc(4);
        end
        cyc(gap);
        rd(twp_pkg::A_TICK_COUNT, v1);
        chk_out(v1 - v0, exp);
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk)
        if (wdt_reset === 1'b1)
            wd_cnt++;
    initial
    begin
        #2000000;
        fails++;
        final_report;
    end

    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial
    begin
        {rst_n, reg_wr, reg_rd, sleeping, tick_lvl, osc_run} = 6'h00;
        {reg_addr, reg_wdata, instr, wd_cnt} = '0;
        {fails, num_checks, ext_en, ext5, ext6} = {64'h0, 13'h1cff};
        ropt_lvl = 2'b01;
        repeat (10) @(posedge core_clk);
        rst_n <= 1'b1;
        chk_reset;
        foreach (rows[i])
        begin
            wr(rows[i].a, rows[i].d);
            chk_rd(rows[i].a, rows[i].e);
        end
        wr(twp_pkg::A_PORT5_DATA, 8'h0a);
        wr(twp_pkg::A_PORT6_DATA, 8'h00);
        cyc(1);
        chk_out({4'h0, port5_out}, 8'h0a);
        chk_out({4'h0, port5_oe}, 8'h0a);
        chk_out(port6_oe, 8'hc3);
        chk_out(pullup_en, 8'ha5);
        chk_out(pulldown_en, 8'ha5);
        wr(twp_pkg::A_PORT6_DATA, 8'hff);
        cyc(1);
        chk_out(port6_oe, 8'h42);
        chk_out(port6_out, 8'h5a);
        wr(twp_pkg::A_PORT6_DIR, 8'hff);
        wr(twp_pkg::A_WDT_PIN, 8'h40);
        wr(twp_pkg::A_IRQ_MASK, 8'h04);
        chk_rd(twp_pkg::A_PORT6_DATA, 8'hff);
        @(posedge core_clk);
        ext6[0] <= 1'b0;
        cyc(6);
        chk_rd(twp_pkg::A_IRQ_FLAGS, 8'h04);
        wr(twp_pkg::A_IRQ_FLAGS, 8'h00);
        wr(twp_pkg::A_WDT_PIN, 8'h00);
        ext6[0] <= 1'b1;
        cyc(6);
        @(posedge core_clk);
        ext6[0] <= 1'b0;
        cyc(6);
        chk_rd(twp_pkg::A_IRQ_FLAGS, 8'h00);
        // port6 is read after the change source is enabled
        wr(twp_pkg::A_IRQ_MASK, 8'h02);
        chk_rd(twp_pkg::A_PORT6_DATA, 8'hfe);
        wr(twp_pkg::A_IRQ_FLAGS, 8'h00);
        chk_rd(twp_pkg::A_IRQ_FLAGS, 8'h00);
        @(posedge core_clk);
        sleeping <= 1'b1;
        ext6[5]  <= 1'b0;
        cyc(6);
        chk_rd(twp_pkg::A_IRQ_FLAGS, 8'h02);
        chk_out({7'h0, wake_req}, 8'h01);
        @(posedge core_clk);
        sleeping <= 1'b0;
        wr(twp_pkg::A_PORT5_DIR, 8'h0f);
        wr(twp_pkg::A_WDT_PIN, 8'h10);
        chk_rd(twp_pkg::A_PORT5_DATA, 8'h0d);
        wr(twp_pkg::A_WDT_PIN, 8'h00);
        chk_rd(twp_pkg::A_PORT5_DATA, 8'h0c);
        wr(twp_pkg::A_TIMER_CTRL, 8'h08);
        wr(twp_pkg::A_IRQ_MASK, 8'h01);
        wr(twp_pkg::A_TICK_COUNT, 8'hfe);
        cyc(8);
        chk_rd(twp_pkg::A_IRQ_FLAGS, 8'h01);
        pulse(0);
        cyc(1);
        chk_out({7'h0, irq_req}, 8'h01);
        wr(twp_pkg::A_IRQ_MASK, 8'h00);
        cyc(1);
        chk_out({7'h0, irq_req}, 8'h00);
        wr(twp_pkg::A_IRQ_MASK, 8'h01);
        wr(twp_pkg::A_IRQ_FLAGS, 8'h00);
        chk_rd(twp_pkg::A_IRQ_FLAGS, 8'h00);
        for (int k = 0; k < 4; k++)
        begin
            pulse(k);
            chk_rd(twp_pkg::A_TIMER_CTRL, (k % 2) ? 8'h08 : 8'h48);
        end
        for (int c = 0; c < 8; c++)
            tick_delta(8'(c), 254, 0, 8'(256 >> (c + 1)));
        tick_delta(8'h08, 98, 0, 8'h64);
        tick_delta(8'h28, 4, 3, 8'h02);
        tick_delta(8'h38, 4, 1, 8'h01);
        wr(twp_pkg::A_TIMER_CTRL, 8'h07);
        rd(twp_pkg::A_PRESCALE_CNT, v0);
        cyc(8);
        rd(twp_pkg::A_PRESCALE_CNT, v1);
        chk_out(v0 - v1, 8'h0a);
        wr(twp_pkg::A_TICK_COUNT, 8'h00);
        chk_rd(twp_pkg::A_PRESCALE_CNT, 8'hff);
        wr(twp_pkg::A_TIMER_CTRL, 8'h28);
        wr(twp_pkg::A_WDT_PIN, 8'h80);
        pulse(4);
        osc_run = 1'b1;
        cyc(80);
        pulse(5);
        wd_cnt = 0;
        cyc(112);
        chk_out(8'(wd_cnt), 8'h00);
        cyc(80);
        chk_out(8'(wd_cnt), 8'h01);
        wr(twp_pkg::A_WDT_PIN, 8'h00);
        pulse(4);
        wd_cnt = 0;
        cyc(300);
        chk_out(8'(wd_cnt), 8'h00);
        osc_run = 1'b0;
        @(posedge core_clk);
        rst_n <= 1'b0;
        cyc(10);
        @(posedge core_clk);
        rst_n <= 1'b1;
        chk_reset;
        chk_out(port6_oe, 8'h00);
        final_report;
    end
endmodule
`default_nettype wire
